//--- orws_pkg.sv
// Package with register map, field positions and timing for the random source
package orws_pkg;
  localparam logic [31:0] GEN_CONTROL_ADDR = 32'h001a_0000;
  localparam logic [31:0] GEN_STATUS_ADDR = 32'h001a_0004;
  localparam logic [31:0] ENTROPY_SEED_ADDR = 32'h001a_0008;
  localparam logic [31:0] RANDOM_OUT_ADDR = 32'h001a_000c;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h001a_0010;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h001a_0014;
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 24;
  localparam int CTL_START_BIT = 0;
  localparam int CTL_HIGH_ASSURANCE_BIT = 1;
  localparam int CTL_IRQ_MASK_BIT = 2;
  localparam int CTL_CLEAR_IRQ_BIT = 3;
  localparam int ST_VIOLATION_BIT = 0;
  localparam int ST_LAST_EMPTY_BIT = 1;
  localparam int ST_UNDERFLOW_BIT = 2;
  localparam int ST_ERROR_BIT = 3;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_CAPACITY_LSB = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [7:0] FIFO_CAPACITY = 8'h10;
  localparam logic [31:0] SHIFT_A_RESET = 32'h1234_5678;
  localparam logic [31:0] SHIFT_B_RESET = 32'h9abc_def1;
  localparam logic [31:0] SHIFT_A_TAPS = 32'h8020_0003;
  localparam logic [31:0] SHIFT_B_TAPS = 32'h8000_0057;
  localparam int PUSH_PERIOD_CYCLES = 256;
  localparam logic [7:0] PUSH_LAST_COUNT = 8'hff;
  localparam int IRQ_EVENTS = 2;
  localparam int EV_UNDERFLOW = 0;
  localparam int EV_PUSH_SKIP = 1;
endpackage

//--- orws_random_source.sv
// Random word source: entropy shifters, output FIFO, APB registers
`timescale 1ns/1ps
module orws_random_source
  import orws_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic errorIrq,
  output logic eventIrq
);

  logic [31:0] shiftA;
  logic [31:0] shiftB;
  logic [7:0] pushCount;
  logic startGo;
  logic highAssurance;
  logic irqMaskBit;
  logic errorFlag;
  logic underflowSeen;
  logic lastPopEmpty;
  logic securityViolation;
  logic [31:0] fifoMem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wrPtr;
  logic [FIFO_AW-1:0] rdPtr;
  logic [FIFO_AW:0] fillLevel;
  logic [IRQ_EVENTS-1:0] evStatus;
  logic [IRQ_EVENTS-1:0] evMask;

  // Bus decode
  wire access = psel && penable;
  wire wrAccess = access && pwrite;
  wire rdAccess = access && !pwrite;
  wire hitCtl = paddr == GEN_CONTROL_ADDR;
  wire hitSt = paddr == GEN_STATUS_ADDR;
  wire hitSeed = paddr == ENTROPY_SEED_ADDR;
  wire hitOut = paddr == RANDOM_OUT_ADDR;
  wire hitEvSt = paddr == IRQ_STATUS_ADDR;
  wire hitEvMask = paddr == IRQ_MASK_ADDR;
  wire mapped = hitCtl || hitSt || hitSeed || hitOut || hitEvSt
                || hitEvMask;
  wire badDir = (hitSeed && !pwrite) || ((hitSt || hitOut) && pwrite);
  wire ctlWrite = wrAccess && hitCtl && pstrb[0];
  wire seedWrite = wrAccess && hitSeed;
  wire statusRead = rdAccess && hitSt;
  wire outRead = rdAccess && hitOut;
  wire fifoEmpty = fillLevel == '0;
  wire fifoFull = fillLevel == (FIFO_AW + 1)'(FIFO_DEPTH);
  wire popOk = outRead && !fifoEmpty;
  wire popEmpty = outRead && fifoEmpty;
  wire pushDue = startGo && pushCount == PUSH_LAST_COUNT;
  wire doPush = pushDue && !fifoFull;
  wire pushSkip = pushDue && fifoFull;
  wire [31:0] seedWord = (seedWrite && pstrb == 4'hf) ? pwdata :
    (seedWrite ? (pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}},
    {8{pstrb[1]}}, {8{pstrb[0]}}}) : 32'h0000_0000);
  wire clearErr = ctlWrite && pwdata[CTL_CLEAR_IRQ_BIT];
  wire [IRQ_EVENTS-1:0] evSet = {pushSkip, popEmpty};
  wire [IRQ_EVENTS-1:0] evClear =
    (wrAccess && hitEvSt) ? pwdata[IRQ_EVENTS-1:0] : '0;

  // Stepped registers; XOR of seed keeps state entropy
  wire [31:0] next_shiftA = {shiftA[30:0], ^(shiftA & SHIFT_A_TAPS)}
                            ^ seedWord;
  wire [31:0] next_shiftB = {shiftB[30:0], ^(shiftB & SHIFT_B_TAPS)}
                            ^ {seedWord[15:0], seedWord[31:16]};
  wire [31:0] randomWord = shiftA ^ shiftB;

  wire [31:0] statusWord = {8'h00, FIFO_CAPACITY,
    3'b000, fillLevel,
    4'h0, errorFlag, underflowSeen, lastPopEmpty, securityViolation};
  wire [31:0] ctlWord = {28'h000_0000, 1'b0, irqMaskBit, highAssurance,
    startGo};
  wire [31:0] next_prdata =
    hitCtl ? ctlWord :
    hitSt ? statusWord :
    hitOut ? (fifoEmpty ? 32'h0000_0000 : fifoMem[rdPtr]) :
    hitEvSt ? {30'h0000_0000, evStatus} :
    hitEvMask ? {30'h0000_0000, evMask} : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access && (!mapped || badDir);
  assign prdata = next_prdata;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shiftA <= SHIFT_A_RESET;
      shiftB <= SHIFT_B_RESET;
    end else begin
      shiftA <= next_shiftA;
      shiftB <= next_shiftB;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pushCount <= 8'h00;
    end else if (startGo) begin
      pushCount <= pushCount + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      startGo <= 1'b0;
      highAssurance <= 1'b0;
      irqMaskBit <= 1'b0;
    end else if (ctlWrite) begin
      startGo <= startGo | pwdata[CTL_START_BIT];
      highAssurance <= highAssurance | pwdata[CTL_HIGH_ASSURANCE_BIT];
      irqMaskBit <= pwdata[CTL_IRQ_MASK_BIT];
    end
  end

  // FIFO storage and pointers
  always_ff @(posedge clk) begin
    if (doPush) begin
      fifoMem[wrPtr] <= randomWord;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fillLevel <= '0;
    end else begin
      wrPtr <= wrPtr + FIFO_AW'(doPush);
      rdPtr <= rdPtr + FIFO_AW'(popOk);
      fillLevel <= fillLevel + (FIFO_AW + 1)'(doPush)
                   - (FIFO_AW + 1)'(popOk);
    end
  end

  // Status flags; set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      errorFlag <= 1'b0;
      underflowSeen <= 1'b0;
      lastPopEmpty <= 1'b0;
      securityViolation <= 1'b0;
    end else begin
      errorFlag <= popEmpty || (errorFlag && !clearErr);
      underflowSeen <= popEmpty || (underflowSeen && !statusRead);
      if (outRead) begin
        lastPopEmpty <= fifoEmpty;
      end
      securityViolation <= securityViolation
                           || (popEmpty && highAssurance);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      evStatus <= '0;
      evMask <= '0;
    end else begin
      evStatus <= evSet | (evStatus & ~evClear);
      if (wrAccess && hitEvMask) begin
        evMask <= pwdata[IRQ_EVENTS-1:0];
      end
    end
  end

  assign errorIrq = errorFlag && !irqMaskBit;
  assign eventIrq = |(evStatus & evMask);

  chk_start_gates_push: assert property (@(posedge clk) disable iff (!rst_n)
    !startGo |=> $stable(fillLevel) || $fell(fillLevel))
    else $error("push before start");
  chk_push_period: assert property (@(posedge clk) disable iff (!rst_n)
    doPush |-> ##1 (!doPush) [*8])
    else $error("pushes too close");
  chk_full_skip: assert property (@(posedge clk) disable iff (!rst_n)
    fifoFull && !popOk |=> fillLevel == 5'd16)
    else $error("full fifo overfilled");
  chk_clear_error: assert property (@(posedge clk) disable iff (!rst_n)
    clearErr && !popEmpty |=> !errorFlag)
    else $error("error not cleared");
  chk_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    errorIrq == (errorFlag && !irqMaskBit))
    else $error("irq level wrong");
  chk_ha_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    highAssurance |=> highAssurance)
    else $error("high assurance dropped");
  chk_start_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    startGo |=> startGo)
    else $error("start dropped");
  chk_empty_read_flags: assert property (@(posedge clk)
    disable iff (!rst_n)
    popEmpty |=> errorFlag && underflowSeen && lastPopEmpty)
    else $error("empty read flags missing");
  chk_underflow_clear: assert property (@(posedge clk)
    disable iff (!rst_n)
    statusRead && !popEmpty |=> !underflowSeen)
    else $error("underflow not cleared");
  chk_violation_sticky: assert property (@(posedge clk)
    disable iff (!rst_n)
    securityViolation |=> securityViolation)
    else $error("violation dropped");
  chk_pop_level: assert property (@(posedge clk) disable iff (!rst_n)
    popOk && !doPush |=> fillLevel == $past(fillLevel) - 5'd1)
    else $error("pop did not remove word");

  cov_push: cover property (@(posedge clk) disable iff (!rst_n) doPush);
  cov_full: cover property (@(posedge clk) disable iff (!rst_n) pushSkip);
  cov_empty_read: cover property (@(posedge clk) disable iff (!rst_n)
    popEmpty && !irqMaskBit);
  cov_seed: cover property (@(posedge clk) disable iff (!rst_n)
    seedWrite);

endmodule

//--- orws_apb_host.sv
// APB host model standing in for the processor core
`timescale 1ns/1ps
module orws_apb_host
  import orws_pkg::*;
(
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
  end

  // Entered just after a rising edge; ends one idle edge after the answer
  task automatic xfer(input logic wr, input logic [31:0] a, d,
                      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
endmodule

//--- orws_random_source_bench.sv
// Self-checking bench for the random word source
`timescale 1ns/1ps
module orws_random_source_bench;
  import orws_pkg::*;
  typedef struct {
    logic wr;
    logic [31:0] a, d, exp;
    logic [1:0] irq;
    logic err;
  } orws_row_type;
  localparam logic [31:0] C = GEN_CONTROL_ADDR;
  localparam logic [31:0] S = GEN_STATUS_ADDR;
  localparam logic [31:0] O = RANDOM_OUT_ADDR;
  localparam logic [31:0] V = IRQ_STATUS_ADDR;
  localparam logic [31:0] M = IRQ_MASK_ADDR;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic errorIrq, eventIrq, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  int errCount, cmpCount;
  orws_row_type rows [19];

  orws_random_source DUT(.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .errorIrq(errorIrq), .eventIrq(eventIrq));
  orws_apb_host host(.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic check(input string what, input logic [31:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdChk(input logic [31:0] a, exp);
    host.xfer(1'b0, a, 32'h0, rd, er);
    check("read data", rd, exp);
  endtask

  task automatic printVerdict;
    $display("Comparisons %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    printVerdict();
  end

  initial begin
    errCount = 0;
    cmpCount = 0;
    rst_n = 1'b0;
    rows = '{'{0, S, 0, 32'h0010_0000, 0, 0}, '{0, O, 0, 0, 2, 0},
      '{0, S, 0, 32'h0010_000e, 2, 0}, '{0, S, 0, 32'h0010_000a, 2, 0},
      '{1, C, 4, 0, 0, 0}, '{1, C, 8, 0, 0, 0},
      '{0, S, 0, 32'h0010_0002, 0, 0}, '{1, C, 2, 0, 0, 0},
      '{0, O, 0, 0, 2, 0}, '{1, C, 8, 0, 0, 0}, '{1, C, 0, 0, 0, 0},
      '{0, C, 0, 2, 0, 0}, '{0, S, 0, 32'h0010_0007, 0, 0},
      '{0, V, 0, 1, 0, 0}, '{1, M, 1, 0, 1, 0}, '{1, V, 1, 0, 0, 0},
      '{1, ENTROPY_SEED_ADDR, 32'h1234_abcd, 0, 0, 0},
      '{0, 32'h001a_0020, 0, 0, 0, 1},
      '{0, S, 0, 32'h0010_0003, 0, 0}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      host.xfer(rows[i].wr, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].wr) check("row data", rd, rows[i].exp);
      check("row irq", {errorIrq, eventIrq}, rows[i].irq);
      check("row slverr", er, rows[i].err);
    end
    repeat (300) @(posedge clk);
    rdChk(S, 32'h0010_0003);
    host.xfer(1'b1, C, 32'h1, rd, er);
    repeat (250) @(posedge clk);
    rdChk(S, 32'h0010_0003);
    repeat (10) @(posedge clk);
    rdChk(S, 32'h0010_0103);
    repeat (256 * 17) @(posedge clk);
    rdChk(S, 32'h0010_1003);
    rdChk(C, 32'h3);
    host.xfer(1'b1, C, 32'h0, rd, er);
    rdChk(C, 32'h3);
    rdChk(V, 32'h2);
    host.xfer(1'b0, O, 32'h0, rd, er);
    check("pop slverr", er, 1'b0);
    rdChk(S, 32'h0010_0f01);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdChk(S, 32'h0010_0000);
    rdChk(C, 32'h0);
    printVerdict();
  end
endmodule
